// >>> common/srp_consts.vh
// constants for the serial receive parser: register map, fields, reset values, timing
// assumes a 250 MHz system clock and a 32-bit apb master on an 8-bit byte address
//
// Overview of operation
// R1 - string capture stops at the end character and never stores it
// R2 - after an early end, remaining array bytes up to length are zeroed
// R3 - literal sequence wait takes a pattern of at most six bytes
// R4 - sequence wait stalls the item list until the whole pattern arrives
// R5 - matching is exact per byte; any differing sequence is ignored
// R6 - array sequence wait takes its pattern from the byte array
// R7 - array sequence wait may give an explicit pattern length
// R8 - input items run strictly in list order on the byte stream
// R9 - discard item throws away exactly its byte count
// R10 - fixed-width decimal stores at most the configured digit count
// R11 - only even parity: data ones plus parity bit count even
// R12 - parity recomputed per character and compared with received bit
// R13 - with good parity the command ends normally and falls through
// R14 - parity mismatch aborts at once and branches to the parity target
// R15 - with no timeout set the command waits forever
// R16 - with timeout set, no byte within the interval aborts to timeout target
// R17 - the timeout restarts from zero on every received byte
// R18 - any byte restarts the timeout, useful to the item or not
// R19 - parity and timeout branches coexist, each with its own target
// R20 - array wait without length ends pattern at first zero byte
// R21 - numeric capture runs until digit count or a non-digit
// R22 - frame: start, data, optional even parity, stop, at set baud and polarity
`ifndef SRP_CONSTS_VH
`define SRP_CONSTS_VH
`define SRP_CLK_MHZ 250
`define SRP_TICK_MS 1
`define SRP_MS_CYCLES (`SRP_TICK_MS * `SRP_CLK_MHZ * 1000)
`define SRP_A_CTRL 8'h00
`define SRP_A_BAUD 8'h04
`define SRP_A_TMO 8'h08
`define SRP_A_STAT 8'h0c
`define SRP_A_PATLO 8'h10
`define SRP_A_PATHI 8'h14
`define SRP_A_RESULT 8'h18
`define SRP_A_TARGET 8'h1c
`define SRP_A_ITEM 3'h1
`define SRP_A_ARR 2'h1
`define SRP_CTRL_START 0
`define SRP_CTRL_PAR 1
`define SRP_CTRL_INV 2
`define SRP_BAUD_RST 16'h65b9
`define SRP_TMO_RST 16'h0000
`define SRP_OP_END 3'h0
`define SRP_OP_CAPT 3'h1
`define SRP_OP_WAIT 3'h2
`define SRP_OP_WSTR 3'h3
`define SRP_OP_SKIP 3'h4
`define SRP_OP_NUM 3'h5
`define SRP_WAIT_MAX 5'h06
`define SRP_EXIT_OK 2'h0
`define SRP_EXIT_PAR 2'h1
`define SRP_EXIT_TMO 2'h2
`define SRP_FRAME_BITS 4'h8
`endif

// >>> hdl/srp_top.v
// serial receive parser: uart receiver plus an input item engine behind apb
// assumes rx_pin is asynchronous to clk and baud divisor is at least 16
//
// Register access over APB and the address map are this design's own decisions.
`include "srp_consts.vh"
module srp_top #(
  parameter MS_CYCLES = `SRP_MS_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_pin,
  output reg busy
);
  localparam U_IDLE = 3'h1;
  localparam U_START = 3'h2;
  localparam U_BITS = 3'h4;
  localparam E_IDLE = 5'h01;
  localparam E_FETCH = 5'h02;
  localparam E_RUN = 5'h04;
  localparam E_CHK = 5'h08;
  localparam E_FILL = 5'h10;

  reg [15:0] baud_r;
  reg [15:0] tmo_r;
  reg par_en_r;
  reg inv_r;
  reg [47:0] wpat_r;
  reg [15:0] result_r;
  reg [31:0] target_r;
  reg [15:0] item_m [0:7];
  reg [7:0] arr_m [0:15];
  reg [7:0] hist_m [0:15];
  reg done_r;
  reg [1:0] exit_r;
  reg [15:0] branch_r;

  // receive pin synchroniser
  reg rx_s1_r;
  reg rx_s2_r;
  always @(posedge clk) begin
    rx_s1_r <= rx_pin;
    rx_s2_r <= rx_s1_r;
  end
  wire rxb = rx_s2_r ^ inv_r;

  // uart framing
  reg [2:0] us_r;
  reg [15:0] ucnt_r;
  reg [3:0] ubit_r;
  reg [7:0] ush_r;
  reg byte_v_r;
  reg [7:0] byte_r;
  reg par_bad_r;
  always @(posedge clk) begin
    if (!rst_n) begin
      us_r <= U_IDLE;
      ucnt_r <= 16'h0000;
      ubit_r <= 4'h0;
      ush_r <= 8'h00;
      byte_v_r <= 1'b0;
      byte_r <= 8'h00;
      par_bad_r <= 1'b0;
    end else begin
      byte_v_r <= 1'b0;
      case (us_r)
        U_IDLE: begin
          if (!rxb) begin
            ucnt_r <= {1'b0, baud_r[15:1]};
            us_r <= U_START;
          end
        end
        U_START: begin
          if (ucnt_r != 16'h0000) begin
            ucnt_r <= ucnt_r - 16'h0001;
          end else if (rxb) begin
            us_r <= U_IDLE;
          end else begin
            ucnt_r <= baud_r - 16'h0001;
            ubit_r <= 4'h0;
            us_r <= U_BITS;
          end
        end
        U_BITS: begin
          if (ucnt_r != 16'h0000) begin
            ucnt_r <= ucnt_r - 16'h0001;
          end else if (ubit_r == `SRP_FRAME_BITS) begin
            // stop bit centre; 7e and 8n both shift eight bits
            us_r <= U_IDLE; // R22
            byte_v_r <= 1'b1;
            byte_r <= par_en_r ? {1'b0, ush_r[6:0]} : ush_r;
            par_bad_r <= par_en_r & (^ush_r); // R11 R12
          end else begin
            ucnt_r <= baud_r - 16'h0001;
            ush_r <= {rxb, ush_r[7:1]}; // R22
            ubit_r <= ubit_r + 4'h1;
          end
        end
        default: us_r <= U_IDLE;
      endcase
    end
  end

  // millisecond inactivity timer
  reg [31:0] pre_r;
  reg [15:0] ms_r;
  wire tmo_fire = (tmo_r != 16'h0000) && (ms_r == tmo_r); // R15 R16
  always @(posedge clk) begin
    if (!rst_n || !busy || byte_v_r) begin
      // any byte at all restarts, even junk for the current item
      pre_r <= 32'h0; // R17 R18
      ms_r <= 16'h0000;
    end else if (pre_r == MS_CYCLES - 1) begin
      pre_r <= 32'h0;
      if (!tmo_fire) begin
        ms_r <= ms_r + 16'h0001;
      end
    end else begin
      pre_r <= pre_r + 32'h1;
    end
  end

  // item engine state
  reg [4:0] es_r;
  reg [3:0] ip_r;
  reg [15:0] cur_r;
  reg [4:0] idx_r;
  reg [4:0] scnt_r;
  reg [15:0] acc_r;
  wire [2:0] op = cur_r[2:0];
  wire flg = cur_r[3];
  wire [4:0] len = {1'b0, cur_r[7:4]};
  wire [7:0] ech = cur_r[15:8];

  // pattern length and comparison against the byte history
  reg [4:0] zlen;
  reg [4:0] plen;
  reg [127:0] pvec;
  reg match;
  reg [4:0] pi;
  integer i;
  integer j;
  always @* begin
    zlen = 5'h10;
    pvec = 128'h0;
    for (i = 15; i >= 0; i = i - 1) begin
      if (arr_m[i] == 8'h00) begin
        zlen = i[4:0]; // R20
      end
      pvec[i*8 +: 8] = arr_m[i]; // R6
    end
    if (op == `SRP_OP_WAIT) begin
      pvec = {80'h0, wpat_r};
      plen = (len > `SRP_WAIT_MAX) ? `SRP_WAIT_MAX : len; // R3
    end else begin
      plen = flg ? len : zlen; // R7 R20
    end
    match = (scnt_r >= plen);
    for (i = 0; i < 16; i = i + 1) begin
      pi = plen - 5'h01 - i[4:0];
      if ((i[4:0] < plen) && (hist_m[i] != pvec[pi[3:0]*8 +: 8])) begin
        match = 1'b0; // R5
      end
    end
  end

  wire is_dig = (byte_r >= 8'h30) && (byte_r <= 8'h39);
  wire [15:0] acc_n = {acc_r[12:0], 3'b000} + {acc_r[14:0], 1'b0} + {12'h000, byte_r[3:0]};
  wire zero_item = (op == `SRP_OP_WSTR) ? (plen == 5'h00) :
                   ((op != `SRP_OP_NUM) && (len == 5'h00));

  // apb decode
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite & ~pslverr;
  wire in_item = (paddr[7:5] == `SRP_A_ITEM);
  wire in_arr = (paddr[7:6] == `SRP_A_ARR);
  reg [31:0] rdat;
  reg mapped;
  always @* begin
    mapped = (paddr[1:0] == 2'b00);
    rdat = 32'h0;
    if (in_arr) begin
      rdat = {24'h0, arr_m[paddr[5:2]]};
    end else if (in_item) begin
      rdat = {16'h0, item_m[paddr[4:2]]};
    end else begin
      case (paddr)
        `SRP_A_CTRL: rdat = {29'h0, inv_r, par_en_r, busy};
        `SRP_A_BAUD: rdat = {16'h0, baud_r};
        `SRP_A_TMO: rdat = {16'h0, tmo_r};
        `SRP_A_STAT: rdat = {branch_r, 8'h0, ip_r, exit_r, done_r, busy};
        `SRP_A_PATLO: rdat = wpat_r[31:0];
        `SRP_A_PATHI: rdat = {16'h0, wpat_r[47:32]};
        `SRP_A_RESULT: rdat = {16'h0, result_r};
        `SRP_A_TARGET: rdat = target_r;
        default: mapped = 1'b0;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      // one wait-free access cycle after every setup
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & mapped & ~pwrite) ? rdat : 32'h0;
    end
  end

  // registers and item engine; software writes are refused while busy
  always @(posedge clk) begin
    if (!rst_n) begin
      baud_r <= `SRP_BAUD_RST;
      tmo_r <= `SRP_TMO_RST;
      par_en_r <= 1'b0;
      inv_r <= 1'b0;
      wpat_r <= 48'h0;
      result_r <= 16'h0000;
      target_r <= 32'h0;
      busy <= 1'b0;
      done_r <= 1'b0;
      exit_r <= `SRP_EXIT_OK;
      branch_r <= 16'h0000;
      es_r <= E_IDLE;
      ip_r <= 4'h0;
      cur_r <= 16'h0000;
      idx_r <= 5'h00;
      scnt_r <= 5'h00;
      acc_r <= 16'h0000;
    end else if (es_r == E_IDLE) begin
      if (wr && in_arr) begin
        arr_m[paddr[5:2]] <= pwdata[7:0];
      end
      if (wr && in_item) begin
        item_m[paddr[4:2]] <= pwdata[15:0];
      end
      if (wr) begin
        case (paddr)
          `SRP_A_CTRL: begin
            par_en_r <= pwdata[`SRP_CTRL_PAR];
            inv_r <= pwdata[`SRP_CTRL_INV];
            if (pwdata[`SRP_CTRL_START]) begin
              busy <= 1'b1;
              done_r <= 1'b0;
              exit_r <= `SRP_EXIT_OK;
              branch_r <= 16'h0000;
              ip_r <= 4'h0;
              es_r <= E_FETCH;
            end
          end
          `SRP_A_BAUD: baud_r <= pwdata[15:0];
          `SRP_A_TMO: tmo_r <= pwdata[15:0];
          `SRP_A_PATLO: wpat_r[31:0] <= pwdata;
          `SRP_A_PATHI: wpat_r[47:32] <= pwdata[15:0];
          `SRP_A_TARGET: target_r <= pwdata;
          default: ;
        endcase
      end
    end else if (byte_v_r && par_bad_r) begin
      // abort beats whatever item is pending
      busy <= 1'b0; // R14
      done_r <= 1'b1;
      exit_r <= `SRP_EXIT_PAR; // R19
      branch_r <= target_r[15:0]; // R14
      es_r <= E_IDLE;
    end else if (tmo_fire) begin
      busy <= 1'b0; // R16
      done_r <= 1'b1;
      exit_r <= `SRP_EXIT_TMO; // R19
      branch_r <= target_r[31:16]; // R16
      es_r <= E_IDLE;
    end else begin
      case (es_r)
        E_FETCH: begin
          cur_r <= item_m[ip_r[2:0]];
          idx_r <= 5'h00;
          scnt_r <= 5'h00;
          acc_r <= 16'h0000;
          if (ip_r[3] || (item_m[ip_r[2:0]][2:0] == `SRP_OP_END)) begin
            busy <= 1'b0; // R13
            done_r <= 1'b1;
            exit_r <= `SRP_EXIT_OK;
            es_r <= E_IDLE;
          end else begin
            es_r <= E_RUN;
          end
        end
        E_RUN: begin
          if (zero_item) begin
            ip_r <= ip_r + 4'h1;
            es_r <= E_FETCH;
          end else if (byte_v_r) begin
            case (op)
              `SRP_OP_CAPT: begin
                if (flg && (byte_r == ech)) begin
                  es_r <= E_FILL; // R1
                end else begin
                  arr_m[idx_r[3:0]] <= byte_r;
                  idx_r <= idx_r + 5'h01;
                  if (idx_r + 5'h01 == len) begin
                    ip_r <= ip_r + 4'h1; // R8
                    es_r <= E_FETCH;
                  end
                end
              end
              `SRP_OP_WAIT, `SRP_OP_WSTR: begin
                for (j = 15; j > 0; j = j - 1) begin
                  hist_m[j] <= hist_m[j-1];
                end
                hist_m[0] <= byte_r;
                if (scnt_r != 5'h10) begin
                  scnt_r <= scnt_r + 5'h01;
                end
                es_r <= E_CHK;
              end
              `SRP_OP_SKIP: begin
                idx_r <= idx_r + 5'h01;
                if (idx_r + 5'h01 == len) begin
                  ip_r <= ip_r + 4'h1; // R9
                  es_r <= E_FETCH;
                end
              end
              `SRP_OP_NUM: begin
                if (is_dig) begin
                  acc_r <= acc_n;
                  idx_r <= idx_r + 5'h01;
                  if ((len != 5'h00) && (idx_r + 5'h01 == len)) begin
                    result_r <= acc_n; // R10
                    ip_r <= ip_r + 4'h1;
                    es_r <= E_FETCH;
                  end
                end else if (idx_r != 5'h00) begin
                  result_r <= acc_r; // R21
                  ip_r <= ip_r + 4'h1;
                  es_r <= E_FETCH;
                end
              end
              default: begin
                busy <= 1'b0;
                done_r <= 1'b1;
                es_r <= E_IDLE;
              end
            endcase
          end
        end
        E_CHK: begin
          if (match) begin
            ip_r <= ip_r + 4'h1;
            es_r <= E_FETCH;
          end else begin
            es_r <= E_RUN; // R4
          end
        end
        E_FILL: begin
          if (idx_r >= len) begin
            ip_r <= ip_r + 4'h1;
            es_r <= E_FETCH;
          end else begin
            arr_m[idx_r[3:0]] <= 8'h00; // R2
            idx_r <= idx_r + 5'h01;
          end
        end
        default: es_r <= E_IDLE;
      endcase
    end
  end
endmodule

// >>> bench/srp_monitor.sv
// checker on the apb port, busy flag and receive line
// assumes srp_top ports; one domain, synchronous reset
module srp_monitor #(
  parameter MS_CYCLES = 20
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rx_pin,
  input wire busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  wire go = acc && pwrite && paddr == 8'h00 && pwdata[0];
  logic [15:0] tmo_r;
  logic rx_q;
  int idle_r;
  // idle counter restarts on any line edge, so slack covers the stop bit tail
  always @(posedge clk) begin
    rx_q <= rx_pin;
    if (!rst_n) tmo_r <= 16'h0;
    else if (acc && pwrite && paddr == 8'h08 && !busy) tmo_r <= pwdata[15:0];
    if (!busy || rx_pin != rx_q) idle_r <= 0;
    else idle_r <= idle_r + 1;
  end
  chk_ready_next: assert property (setup |=> pready) else $error("no pready after setup");
  chk_ready_cause: assert property (!setup |=> !pready) else $error("pready without setup");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  chk_err_align: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr) else $error("misaligned accepted");
  chk_err_range: assert property (setup && paddr[7] |=> pslverr) else $error("unmapped accepted");
  chk_ok_mapped: assert property (setup && !paddr[7] && paddr[1:0] == 2'h0 |=> !pslverr) else $error("bad pslverr");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside access");
  chk_start_busy: assert property (go && !busy |=> busy [*2]) else $error("start ignored");
  chk_busy_cause: assert property (!busy && !go |=> !busy) else $error("busy without start");
  chk_tmo_bound: assert property (busy && tmo_r != 16'h0 |-> idle_r <= tmo_r * MS_CYCLES + 64)
    else $error("timeout overdue");
endmodule
bind srp_top srp_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_pin(rx_pin), .busy(busy));

// >>> bench/srp_sender.sv
// remote serial sender on the receive line
// assumes calls right after a rising edge; line idles high
module srp_sender #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic inv = 1'b0;
  initial line = 1'b1;
  // inverted polarity idles low
  task set_inv(input logic v);
    inv = v;
    line <= ~v;
  endtask
  // parity mode puts even parity in bit 7; bad flips it on purpose
  task send_byte(input logic [7:0] b, input logic par, input logic bad);
    logic [9:0] f;
    f = {1'b1, par ? {^b[6:0] ^ bad, b[6:0]} : b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i] ^ inv;
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask
  task send_text(input string s, input logic par, input int gap);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i], par, 1'b0);
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule

// >>> bench/test_serial_receive_parser.sv
// self-checking bench for the serial receive parser
// assumes srp_top, the srp_sender model and the bound checker
`include "srp_consts.vh"
module test_serial_receive_parser;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, rx_pin, busy, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int mismatches, check_count, n;
  srp_top #(.MS_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .busy(busy));
  srp_sender #(.BIT_CYCLES(16)) u_tx (.clk(clk), .line(rx_pin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one idle cycle after each transfer so no signal is assigned twice at one edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] ad(input int base, input int i);
    return 8'(base + 4 * i);
  endfunction
  function automatic logic [31:0] itm(input logic [2:0] op, input logic fl, input logic [3:0] len,
    input logic [7:0] ch);
    return {16'h0, ch, len, fl, op};
  endfunction
  task prog(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c, input logic [31:0] ctrl);
    apb(ad(32, 0), 1'b1, a);
    apb(ad(32, 1), 1'b1, b);
    apb(ad(32, 2), 1'b1, c);
    apb(ad(32, 3), 1'b1, 32'h0);
    apb(`SRP_A_CTRL, 1'b1, ctrl);
  endtask
  task wait_idle;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, busy}, 32'h0);
  endtask
  task status(input logic [1:0] ex, input logic [15:0] tg);
    apb(`SRP_A_STAT, 1'b0, 32'h0);
    check(rdata & 32'hffff000c, {tg, 12'h0, ex, 2'h0});
  endtask
  task t_regs;
    apb(`SRP_A_BAUD, 1'b0, 32'h0);
    check(rdata, {16'h0, `SRP_BAUD_RST});
    apb(`SRP_A_TMO, 1'b0, 32'h0);
    check(rdata, {16'h0, `SRP_TMO_RST});
    apb(8'h80, 1'b0, 32'h0);
    check({31'h0, rerr}, 32'h1);
    apb(`SRP_A_BAUD, 1'b1, 32'h10);
    apb(`SRP_A_TARGET, 1'b1, 32'h0222_0111);
  endtask
  task t_string;
    for (int i = 0; i < 10; i++) apb(ad(64, i), 1'b1, 32'hff);
    prog(itm(`SRP_OP_CAPT, 1'b1, 4'h9, 8'h2a), 32'h0, 32'h0, 32'h1);
    u_tx.send_text("hi*", 1'b0, 0);
    wait_idle;
    status(`SRP_EXIT_OK, 16'h0);
    for (int i = 0; i < 10; i++) begin
      apb(ad(64, i), 1'b0, 32'h0);
      check(rdata, i == 0 ? 32'h68 : i == 1 ? 32'h69 : i < 9 ? 32'h0 : 32'hff);
    end
  endtask
  // a skip of the wrong length shifts which digits reach the decimal item
  task t_compound;
    apb(`SRP_A_PATLO, 1'b1, 32'h6261);
    prog(itm(`SRP_OP_WAIT, 1'b0, 4'h2, 8'h0), itm(`SRP_OP_SKIP, 1'b0, 4'h2, 8'h0),
      itm(`SRP_OP_NUM, 1'b0, 4'h4, 8'h0), 32'h1);
    u_tx.send_text("aXaB", 1'b0, 0);
    check({31'h0, busy}, 32'h1);
    u_tx.send_text("ab4512345", 1'b0, 0);
    wait_idle;
    apb(`SRP_A_RESULT, 1'b0, 32'h0);
    check(rdata, 32'd1234);
  endtask
  task t_array;
    apb(ad(64, 0), 1'b1, 32'h78);
    apb(ad(64, 1), 1'b1, 32'h79);
    apb(ad(64, 2), 1'b1, 32'h0);
    prog(itm(`SRP_OP_WSTR, 1'b0, 4'h0, 8'h0), itm(`SRP_OP_WSTR, 1'b1, 4'h1, 8'h0), 32'h0, 32'h1);
    u_tx.send_text("xzxyy", 1'b0, 0);
    check({31'h0, busy}, 32'h1);
    u_tx.send_text("x", 1'b0, 0);
    wait_idle;
    status(`SRP_EXIT_OK, 16'h0);
  endtask
  task t_parity;
    apb(`SRP_A_TMO, 1'b1, 32'hc);
    prog(itm(`SRP_OP_SKIP, 1'b0, 4'h3, 8'h0), 32'h0, 32'h0, 32'h3);
    u_tx.send_byte(8'h41, 1'b1, 1'b0);
    check({31'h0, busy}, 32'h1);
    u_tx.send_byte(8'h42, 1'b1, 1'b1);
    wait_idle;
    status(`SRP_EXIT_PAR, 16'h0111);
  endtask
  // 12 ms of 20 cycles is 240 cycles, longer than one frame plus gap
  task t_timeout;
    prog(itm(`SRP_OP_NUM, 1'b0, 4'h0, 8'h0), 32'h0, 32'h0, 32'h1);
    u_tx.send_text("ABC", 1'b0, 40);
    check({31'h0, busy}, 32'h1);
    wait_idle;
    check({31'h0, n > 150 && n < 260}, 32'h1);
    status(`SRP_EXIT_TMO, 16'h0222);
  endtask
  // invert first, then flip the line: the half-bit check drops the false start
  task t_forever;
    apb(`SRP_A_CTRL, 1'b1, 32'h4);
    u_tx.set_inv(1'b1);
    repeat (20) @(posedge clk);
    apb(`SRP_A_TMO, 1'b1, 32'h0);
    prog(itm(`SRP_OP_NUM, 1'b0, 4'h1, 8'h0), 32'h0, 32'h0, 32'h5);
    repeat (3000) @(posedge clk);
    check({31'h0, busy}, 32'h1);
    apb(`SRP_A_CTRL, 1'b0, 32'h0);
    check(rdata, 32'h5);
    u_tx.send_text("7", 1'b0, 0);
    wait_idle;
    status(`SRP_EXIT_OK, 16'h0);
    apb(`SRP_A_RESULT, 1'b0, 32'h0);
    check(rdata, 32'h7);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_string;
    t_compound;
    t_array;
    t_parity;
    t_timeout;
    t_forever;
    tally_and_finish;
  end
endmodule
